/* File: fpdc_unit.sv */
// floating divide (double) and fixed-to-float convert (single) datapath
// assumes sequencer holds operands valid during the start pulse only
`timescale 1ns/1ps
module fpdc_unit (
  input wire logic clk_sys, // processor clock, 10 MHz
  input wire logic reset, // synchronous, active high
  input wire logic startDiv, // pulse: start double divide
  input wire logic startCvt, // pulse: start single convert
  input wire logic [71:0] dividendIn, // from two control registers
  input wire logic [71:0] divisorIn, // from two storage words
  input wire logic [35:0] cvtCharIn, // first convert operand
  input wire logic [35:0] cvtFixIn, // signed fixed operand
  input wire logic underflow_zero_select, // state bit: zero on divide underflow
  input wire logic zero_compat_select, // state bit: legacy zero rules
  output logic busy, // operation in progress
  output logic done, // one-cycle pulse at completion
  output logic [71:0] result, // divide result, or convert in low 36
  output logic resultWide, // result is a two-word value
  output logic divFault, // zero divisor
  output logic ovfFault, // characteristic overflow
  output logic unfFault // characteristic underflow
);
  import fpdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state, grouped as control, divide datapath and convert datapath
  fpdc_state_e state_reg, state_next;
  logic [6:0] cnt_reg, cnt_next;
  logic firstBorrow_reg, firstBorrow_next;
  logic negRes_reg, negRes_next;
  logic busy_reg, busy_next, done_reg, done_next, wide_reg, wide_next;
  logic dF_reg, dF_next, oF_reg, oF_next, uF_reg, uF_next;
  logic [DW-1:0] res_reg, res_next;
  logic [DW-1:0] rem_reg, rem_next, dvs_reg, dvs_next, quo_reg, quo_next;
  logic [10:0] chA_reg, chA_next, chB_reg, chB_next;
  logic [SW-1:0] op_reg, op_next;
  logic [8:0] sch_reg, sch_next;

  ////////////////////////////////////////////////////////////////////////
  // helper functions
  // leading-one position of a 36-bit word, 63 when zero
  function automatic logic [5:0] lead_one(input logic [35:0] v);
    logic [5:0] p;
    p = 6'h3F;
    for (int i = 0; i < 36; i++) begin
      if (v[i]) p = 6'(i);
    end
    return p;
  endfunction

  // ones complement of a double word when asked for
  function automatic logic [71:0] comp72(input logic inv, input logic [71:0] v);
    return inv ? ~v : v;
  endfunction

  // ones complement of a single word when asked for
  function automatic logic [35:0] comp36(input logic inv, input logic [35:0] v);
    return inv ? ~v : v;
  endfunction

  // double-precision mantissa field all zero
  function automatic logic mant_zero(input logic [71:0] v);
    return v[DCH_LSB-1:0] == 60'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // shared decode of the start pulses and the loop position
  logic idle, takeDiv, takeCvt, inLoop, lastCycle;
  assign idle = (state_reg == FPDC_IDLE);
  assign takeDiv = idle && startDiv;
  // divide wins when both pulses come together
  assign takeCvt = idle && !startDiv && startCvt;
  assign inLoop = (state_reg == FPDC_DFIRST) || (state_reg == FPDC_DLOOP);
  assign lastCycle = (state_reg == FPDC_DLOOP) && (cnt_reg == 7'h01);

  ////////////////////////////////////////////////////////////////////////
  // divide arithmetic: main adder and characteristic adder
  logic [72:0] diff;
  logic borrow;
  logic [12:0] chDiff, qChar;
  logic [71:0] dvdAbs, dvsAbs, packed72;
  // main adder: borrow out of the top bit when the difference goes negative
  assign diff = {1'b0, rem_reg} - {1'b0, dvs_reg};
  assign borrow = diff[72];
  // operands made positive before unpacking
  assign dvdAbs = comp72(dividendIn[71], dividendIn);
  assign dvsAbs = comp72(divisorIn[71], divisorIn);
  // a bit above the 12-bit sum keeps overflow apart from negative
  assign chDiff = {2'b00, chA_reg} - {2'b00, chB_reg};
  assign qChar = chDiff + {1'b0, firstBorrow_reg ? DBIAS_BORROW : DBIAS_NOBORROW};
  // characteristic laid over the cleared field
  assign packed72 = {quo_reg[DCH_MSB+1], qChar[10:0], quo_reg[DCH_LSB-1:0]};

  ////////////////////////////////////////////////////////////////////////
  // convert arithmetic: normalizer and 9-bit characteristic adder
  logic [35:0] fixAbs, normed, pack36;
  logic [5:0] lead, shCnt;
  logic rightShift;
  logic [9:0] rChar;
  logic cvtMantZero;
  assign fixAbs = comp36(cvtFixIn[35], cvtFixIn);
  assign lead = lead_one(op_reg);
  // leading one moved to bit 26, shift counted
  always_comb begin
    rightShift = 1'b0;
    shCnt = SZERO_COUNT;
    normed = op_reg;
    if (lead != 6'h3F) begin
      if (lead > SNORM_BIT) begin
        rightShift = 1'b1;
        shCnt = lead - SNORM_BIT;
        normed = op_reg >> shCnt;
      end else begin
        shCnt = SNORM_BIT - lead;
        normed = op_reg << shCnt;
      end
    end
  end
  // one extra bit catches negative results
  assign rChar = rightShift ? {1'b0, sch_reg} + 10'(shCnt)
                            : {1'b0, sch_reg} - 10'(shCnt);
  assign cvtMantZero = (normed[26:0] == 27'h0);
  // packer; only a legacy zero can reach the store with a negative value
  always_comb begin
    pack36 = normed;
    pack36[35] = 1'b0;
    pack36[SCH_MSB:SCH_LSB] = rChar[7:0];
    if (rChar[9]) pack36[35:27] = 9'h000;
  end

  ////////////////////////////////////////////////////////////////////////
  // control: sequence, status flags and result word
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    firstBorrow_next = firstBorrow_reg;
    negRes_next = negRes_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    wide_next = wide_reg;
    dF_next = dF_reg;
    oF_next = oF_reg;
    uF_next = uF_reg;
    res_next = res_reg;
    case (state_reg)
      FPDC_IDLE: begin
        if (takeDiv) begin
          negRes_next = dividendIn[71] ^ divisorIn[71];
          {busy_next, wide_next, dF_next, oF_next, uF_next} = 5'b11000;
          if (mant_zero(dvsAbs)) begin
            dF_next = 1'b1;
            done_next = 1'b1;
            busy_next = 1'b0;
          end else begin
            state_next = FPDC_DFIRST;
          end
        end else if (takeCvt) begin
          negRes_next = cvtFixIn[35];
          {busy_next, wide_next, dF_next, oF_next, uF_next} = 5'b10000;
          state_next = FPDC_CNORM;
        end
      end
      FPDC_DFIRST: begin
        // the first borrow fixes how many cycles remain
        firstBorrow_next = borrow;
        cnt_next = borrow ? DIV_CYCLES_EXTRA_BORROW : DIV_CYCLES_EXTRA_NOBORROW;
        state_next = FPDC_DLOOP;
      end
      FPDC_DLOOP: begin
        cnt_next = cnt_reg - 7'h01;
        if (lastCycle) state_next = FPDC_DPACK;
      end
      FPDC_DPACK: begin
        state_next = FPDC_IDLE;
        busy_next = 1'b0;
        done_next = 1'b1;
        if (mant_zero(quo_reg)) begin
          res_next = '0;
        end else if (!qChar[12] && qChar[11:0] > DCHAR_MAX) begin
          oF_next = 1'b1;
        end else if (qChar[12]) begin
          if (underflow_zero_select) res_next = '0;
          else uF_next = 1'b1;
        end else begin
          res_next = comp72(negRes_reg, packed72);
        end
      end
      FPDC_CNORM: begin
        state_next = FPDC_IDLE;
        busy_next = 1'b0;
        done_next = 1'b1;
        if (!rChar[9] && rChar > {1'b0, SCHAR_MAX}) begin
          oF_next = 1'b1;
        end else if (rChar[9] && !cvtMantZero) begin
          uF_next = 1'b1;
        end else if (cvtMantZero && !zero_compat_select) begin
          res_next = '0;
        end else begin
          res_next = {36'h0, comp36(negRes_reg, pack36)};
        end
      end
      default: begin
        state_next = FPDC_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // divide datapath: load, subtract and rotate
  always_comb begin
    rem_next = rem_reg;
    dvs_next = dvs_reg;
    quo_next = quo_reg;
    chA_next = chA_reg;
    chB_next = chB_reg;
    if (takeDiv) begin
      // characteristics saved before their field is cleared
      chA_next = dvdAbs[DCH_MSB:DCH_LSB];
      chB_next = dvsAbs[DCH_MSB:DCH_LSB];
      rem_next = {dvdAbs[71], 11'h000, dvdAbs[59:0]};
      dvs_next = {dvsAbs[71], 11'h000, dvsAbs[59:0]};
      quo_next = '0;
    end else if (inLoop) begin
      // one subtract cycle per clock
      if (!borrow) begin
        rem_next = diff[71:0];
        quo_next = {quo_reg[71:1], 1'b1};
      end
      // rotate after every cycle but the last
      if (!lastCycle) begin
        rem_next = {rem_next[70:0], rem_next[71]};
        quo_next = {quo_next[70:0], quo_next[71]};
      end
    end
  end

  // convert datapath: operands captured at the start pulse
  always_comb begin
    op_next = op_reg;
    sch_next = sch_reg;
    if (takeCvt) begin
      sch_next = {1'b0, cvtCharIn[7:0]};
      op_next = fixAbs;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= FPDC_IDLE;
      cnt_reg <= '0;
      firstBorrow_reg <= 1'b0;
      negRes_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      wide_reg <= 1'b0;
      dF_reg <= 1'b0;
      oF_reg <= 1'b0;
      uF_reg <= 1'b0;
      res_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      firstBorrow_reg <= firstBorrow_next;
      negRes_reg <= negRes_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      wide_reg <= wide_next;
      dF_reg <= dF_next;
      oF_reg <= oF_next;
      uF_reg <= uF_next;
      res_reg <= res_next;
    end
  end

  // divide registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rem_reg <= '0;
      dvs_reg <= '0;
      quo_reg <= '0;
      chA_reg <= '0;
      chB_reg <= '0;
    end else begin
      rem_reg <= rem_next;
      dvs_reg <= dvs_next;
      quo_reg <= quo_next;
      chA_reg <= chA_next;
      chB_reg <= chB_next;
    end
  end

  // convert registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_reg <= '0;
      sch_reg <= '0;
    end else begin
      op_reg <= op_next;
      sch_reg <= sch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign busy = busy_reg;
  assign done = done_reg;
  assign result = res_reg;
  assign resultWide = wide_reg;
  assign divFault = dF_reg;
  assign ovfFault = oF_reg;
  assign unfFault = uF_reg;
endmodule // fpdc_unit

/* File: fpdc_pkg.sv */
// constants for the floating divide and convert datapath
// assumes a single synchronous clock domain and a sequencer that pulses start
// Functional notes
// - divide loads 72-bit dividend from control regs, divisor from storage
// - quotient sign from operand signs, zero is positive, negatives complemented
// - clear bits 70..60 of both, zero quotient, zero divisor gives divide fault
// - 60 or 61 subtract cycles depending on first-cycle borrow
// - no borrow keeps difference and sets quotient lsb, borrow discards it
// - rotate dividend and quotient left after every cycle but the last
// - low 60 quotient bits hold the absolute mantissa when done
// - 12-bit adder forms dividend minus divisor characteristic
// - zero quotient mantissa stores all-zero result regardless of signs
// - bias 2001 octal without first borrow, 2000 octal with it
// - nonzero mantissa and characteristic above 3777 octal reports overflow
// - negative characteristic: underflow fault, or zero result if select set
// - pack 11-bit characteristic at 70..60, complement if signs differ, store
// - conversion takes low eight bits into 9-bit characteristic, top zero
// - 36-bit fixed operand loaded, complemented if negative, sign kept
// - normalize leading one to bit 26, counts right 1-8, left 1-26, zero 27
// - add count after right shift else subtract, store at bits 34..27
// - conversion characteristic above 377 octal reports overflow
// - negative characteristic with nonzero mantissa reports underflow
// - zero mantissa with compat clear stores all-zero result
// - zero mantissa, compat set, negative characteristic clears 35..27 then signs
// - negative input complements result, written to one control register
// - compat select 0 normal zero handling, 1 legacy zero conventions
package fpdc_pkg;
  localparam int DW = 72;
  localparam int SW = 36;
  localparam int DCH_LSB = 60;
  localparam int DCH_MSB = 70;
  localparam logic [11:0] DBIAS_NOBORROW = 12'h401; // 2001 octal
  localparam logic [11:0] DBIAS_BORROW = 12'h400; // 2000 octal
  localparam logic [11:0] DCHAR_MAX = 12'h7FF; // 3777 octal
  localparam logic [6:0] DIV_CYCLES_EXTRA_BORROW = 7'h3C; // 60
  localparam logic [6:0] DIV_CYCLES_EXTRA_NOBORROW = 7'h3B; // 59
  localparam int SCH_LSB = 27;
  localparam int SCH_MSB = 34;
  localparam logic [8:0] SCHAR_MAX = 9'h0FF; // 377 octal
  localparam logic [5:0] SNORM_BIT = 6'h1A; // 26
  localparam logic [5:0] SZERO_COUNT = 6'h1B; // 27
  typedef enum logic [2:0] {
    FPDC_IDLE = 3'b000,
    FPDC_DFIRST = 3'b001,
    FPDC_DLOOP = 3'b010,
    FPDC_DPACK = 3'b011,
    FPDC_CNORM = 3'b100,
    FPDC_CPACK = 3'b101
  } fpdc_state_e;
endpackage

/* File: fpdc_unit_assertions.sv */
// port checker for the divide and convert unit
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
module fpdc_unit_assertions (
  input wire logic clk_sys, // clock
  input wire logic reset, // sync reset
  input wire logic startDiv, // divide start
  input wire logic startCvt, // convert start
  input wire logic [71:0] divisorIn, // divisor
  input wire logic busy, // in progress
  input wire logic done, // completion
  input wire logic [71:0] result, // result
  input wire logic resultWide, // two-word flag
  input wire logic divFault, // divide fault
  input wire logic ovfFault, // overflow
  input wire logic unfFault // underflow
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic tookReg;
  // remembers a taken start so that fault changes can be traced to it
  always_ff @(posedge clk_sys) tookReg <= (startDiv || startCvt) && !busy;
  sequence s_divGo; startDiv && !busy; endsequence
  sequence s_cvtGo; startCvt && !startDiv && !busy; endsequence
  sequence s_cvtWalk; busy && !done ##1 done && !busy; endsequence
  // sign-corrected divisor magnitude picks fault or long loop
  wire logic zeroDvs = (divisorIn[71] ? ~divisorIn[59:0] : divisorIn[59:0]) == 60'h0;
  a_div_bounded: assert property (s_divGo |-> ##[1:63] done)
    else $error("divide did not finish in time");
  a_div_zero: assert property (startDiv && !busy && zeroDvs |=> done && divFault)
    else $error("zero divisor not faulted at once");
  a_div_loop: assert property (startDiv && !busy && !zeroDvs |=> (busy && !done)[*8])
    else $error("divide ended too early");
  a_cvt_walk: assert property (s_cvtGo |=> s_cvtWalk)
    else $error("convert timing wrong");
  a_one_fault: assert property (done |-> $onehot0({divFault, ovfFault, unfFault}))
    else $error("more than one fault");
  a_cvt_narrow: assert property (done && !resultWide && !divFault && !ovfFault && !unfFault
    |-> result[71:36] == 36'h0)
    else $error("convert result wider than one word");
  a_result_still: assert property ($changed(result) |-> done)
    else $error("result moved without done");
  a_fault_hold: assert property ($changed({divFault, ovfFault, unfFault}) |-> done || tookReg)
    else $error("fault flags moved on their own");
endmodule // fpdc_unit_assertions
bind fpdc_unit fpdc_unit_assertions fpdc_unit_assertions_inst (.clk_sys, .reset, .startDiv,
  .startCvt, .divisorIn, .busy, .done, .result, .resultWide, .divFault, .ovfFault, .unfFault);

/* File: fpdc_seq_model.sv */
// sequencer model: hands one operation at a time to the unit
// assumes the bench calls issue from a falling edge
`timescale 1ns/1ps
module fpdc_seq_model (
  input wire logic clk_sys, // processor clock
  output logic startDiv, // divide start pulse
  output logic startCvt, // convert start pulse
  output logic [71:0] dividendIn, // dividend
  output logic [71:0] divisorIn, // divisor
  output logic [35:0] cvtCharIn, // convert characteristic
  output logic [35:0] cvtFixIn // convert fixed operand
);
  initial begin
    {startDiv, startCvt} = 2'h0;
    {dividendIn, divisorIn, cvtCharIn, cvtFixIn} = '0;
  end
  // operands go stale after the pulse so late sampling shows up
  task automatic issue(input bit isDiv, input logic [71:0] a, b, input logic [35:0] c, x,
      input int gap);
    repeat (gap + 1) @(negedge clk_sys);
    {dividendIn, divisorIn, cvtCharIn, cvtFixIn} = {a, b, c, x};
    {startDiv, startCvt} = {isDiv, !isDiv};
    @(negedge clk_sys);
    {startDiv, startCvt} = 2'h0;
    {dividendIn, divisorIn, cvtCharIn, cvtFixIn} = ~{a, b, c, x};
  endtask
endmodule // fpdc_seq_model

/* File: test_fp_divide_and_convert.sv */
// self-checking bench for the divide and convert unit
// assumes the sequencer model and the bound checker are compiled first
`timescale 1ns/1ps
module test_fp_divide_and_convert;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic uzSel = 1'b0;
  logic zcSel = 1'b0;
  logic startDiv, startCvt, busy, done, resultWide, divFault, ovfFault, unfFault;
  logic [71:0] dividendIn, divisorIn, result, expRes;
  logic [35:0] cvtCharIn, cvtFixIn;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  fpdc_seq_model fpdc_seq_model_inst (.clk_sys, .startDiv, .startCvt, .dividendIn,
    .divisorIn, .cvtCharIn, .cvtFixIn);
  fpdc_unit fpdc_unit_inst (.clk_sys, .reset, .startDiv, .startCvt, .dividendIn, .divisorIn,
    .cvtCharIn, .cvtFixIn, .underflow_zero_select(uzSel), .zero_compat_select(zcSel),
    .busy, .done, .result, .resultWide, .divFault, .ovfFault, .unfFault);
  initial forever #50 clk_sys = ~clk_sys;
  // hang guard, well above the longest expected run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // expected {div, ovf, unf, result} by plain restoring division
  function automatic logic [74:0] divModel(logic [71:0] a, b, logic uz);
    logic [71:0] d, m, q;
    logic fb;
    int ch, n;
    q = 72'h0;
    d = {12'h000, a[71] ? ~a[59:0] : a[59:0]};
    m = {12'h000, b[71] ? ~b[59:0] : b[59:0]};
    ch = int'({a[70:60] ^ {11{a[71]}}}) - int'({b[70:60] ^ {11{b[71]}}});
    if (m == 72'h0) return {3'h4, 72'h0};
    fb = d < m;
    n = fb ? 61 : 60;
    ch = ch + (fb ? 1024 : 1025);
    for (int i = 0; i < n; i++) begin
      if (d >= m) {d, q[0]} = {d - m, 1'b1};
      if (i < n - 1) {d, q} = {d[70:0], d[71], q[70:0], q[71]};
    end
    if (q[59:0] == 60'h0) return 75'h0;
    if (ch > 2047) return {3'h2, 72'h0};
    if (ch < 0) return uz ? 75'h0 : {3'h1, 72'h0};
    q = {1'b0, ch[10:0], q[59:0]};
    return {3'h0, (a[71] ^ b[71]) ? ~q : q};
  endfunction
  // expected {div, ovf, unf, result} for fixed to float
  function automatic logic [74:0] cvtModel(logic [35:0] c, x, logic zc);
    logic [35:0] r;
    int p, ch;
    r = x[35] ? ~x : x;
    p = -1;
    ch = int'(c[7:0]);
    for (int i = 0; i < 36; i++) if (r[i]) p = i;
    if (p < 0) ch = ch - 27;
    else if (p > 26) {ch, r} = {ch + p - 26, r >> (p - 26)};
    else {ch, r} = {ch - 26 + p, r << (26 - p)};
    if (ch > 255) return {3'h2, 72'h0};
    if (ch < 0 && r[26:0] != 27'h0) return {3'h1, 72'h0};
    if (r[26:0] == 27'h0 && !zc) return 75'h0;
    r = ch < 0 ? 36'h0 : {1'b0, ch[7:0], r[26:0]};
    return {39'h0, x[35] ? ~r : r};
  endfunction
  task automatic chk72(input string what, input logic [71:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic results();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one operation through the sequencer, then done, faults and result compared, resultWide only when fault-free
  task automatic doOp(input bit isDiv, input logic [71:0] a, b, input logic [35:0] c, x,
      input logic uz, zc);
    logic [74:0] e;
    {uzSel, zcSel} = {uz, zc};
    fpdc_seq_model_inst.issue(isDiv, a, b, c, x, $urandom % 3);
    for (int i = 0; i < 80 && done !== 1'b1; i++) @(negedge clk_sys);
    e = isDiv ? divModel(a, b, uz) : cvtModel(c, x, zc);
    if (e[74:72] == 3'h0) expRes = e[71:0];
    chk1("done", 1'b1, done);
    chk1("divFault", e[74], divFault);
    chk1("ovfFault", e[73], ovfFault);
    chk1("unfFault", e[72], unfFault);
    chk72("result", expRes, result);
    if (e[74:72] == 3'h0) chk1("resultWide", isDiv, resultWide);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [71:0] a, b;
    logic [35:0] x;
    void'($urandom(39873));
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    expRes = 72'h0;
    chk1("busy", 1'b0, busy);
    chk72("result", 72'h0, result);
    a = 72'h400800000000000000;
    doOp(1, a, 72'h0, 0, 0, 0, 0);
    doOp(1, a, ~72'h0, 0, 0, 0, 0);
    doOp(1, ~72'h400000000000000000, a, 0, 0, 1, 0);
    // characteristic edges: top fit, first overflow, zero, first underflow
    for (int k = 0; k < 4; k++) begin
      a = {1'b0, k < 2 ? 11'h3FE + 11'(k) : 11'h000, 60'h800000000000000};
      b = {1'b0, k < 2 ? 11'h000 : 11'h3FF + 11'(k), 60'h800000000000000};
      doOp(1, a, b, 0, 0, k[0], 0);
    end
    repeat (40) begin
      a = 72'({$urandom, $urandom, $urandom});
      b = 72'({$urandom, $urandom, $urandom});
      {a[59], b[59]} = {~a[71], ~b[71]};
      doOp(1, a, b, 0, 0, $urandom % 2, 0);
    end
    for (int k = 0; k < 8; k++)
      doOp(0, 0, 0, k[1] ? 36'd200 : 36'd5, k[0] ? ~36'h0 : 36'h0, 0, k[2]);
    doOp(0, 0, 0, 36'hFF, 36'h7FFFFFFFF, 0, 0);
    doOp(0, 0, 0, 36'hFFFFFFF04, 36'h1, 0, 0);
    doOp(0, 0, 0, 36'h80, 36'h4000000, 0, 0);
    repeat (80) begin
      x = 36'({$urandom, $urandom} >> (28 + $urandom % 36));
      if ($urandom % 2) x = ~x;
      doOp(0, 0, 0, 36'($urandom), x, 0, $urandom % 2);
    end
    results();
  end
endmodule // test_fp_divide_and_convert
